//--- standby_defs.svh
// Register offsets, field positions and timing constants for the standby controller
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH
`define OFS_PSMODE 8'h00
`define OFS_PSCTRL 8'h04
`define OFS_OSCSET 8'h08
`define OFS_PCLOCK 8'h0c
`define OFS_STATUS 8'h10
`define BIT_DEEP 0
`define BIT_STANDBY 1
`define BIT_MASKABLE_M 4
`define BIT_PIN_NMI_M 5
`define BIT_WDT_NMI_M 6
`define BIT_SUBSEL 3
`define BIT_MAINSTOP 6
`define DIV_MSB 2
`define SETTLE_SEL_W 3
`define SETTLE_SEL_RST 3'h2
`define DIV_RST 3'h3
`define CNT_W 24
`define PRIO_W 3
`define EXT_IRQ_N 7
`define MAIN_OSC_HZ 4000000
`define RESET_SETTLE_CYC 32768
`define SETTLE_BASE 13
`endif

//--- standby_pkg.sv
// Types shared by the standby controller
package standby_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP,
    ST_SETTLE
  } pwr_state_t;
  typedef struct packed {
    logic nmi;
    logic maskable;
  } wake_req_t;
  typedef struct packed {
    logic ack;
    logic branch;
    logic from_irq;
  } wake_plan_t;
endpackage

//--- standby_stop_subclock_control.sv
// Standby controller: stop mode, wake-up, settling wait and subclock mode
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "standby_defs.svh"

module standby_stop_subclock_control
  import standby_pkg::*;
#(
  parameter int RESET_SETTLE_CYC = `RESET_SETTLE_CYC,
  parameter int SETTLE_BASE = `SETTLE_BASE
) (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic NMI_PIN_I,
  input wire logic [`EXT_IRQ_N-1:0] EXT_IRQ_PIN_I,
  input wire logic [`EXT_IRQ_N-1:0] EXT_IRQ_EN_I,
  input wire logic PERIPH_IRQ_I,
  input wire logic WATCHDOG2_IRQ_I,
  input wire logic WATCHDOG2_RESET_I,
  input wire logic WATCHDOG1_RESET_I,
  input wire logic IN_SERVICE_I,
  input wire logic [`PRIO_W-1:0] SERVICE_PRIO_I,
  input wire logic [`PRIO_W-1:0] REQ_PRIO_I,
  input wire logic INT_ENABLE_I,
  input wire logic TIMER16_WT_EN_I,
  output logic MAIN_OSC_EN_O,
  output logic SUB_OSC_EN_O,
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic SYS_CLK_SUB_O,
  output logic [`DIV_MSB:0] CLK_DIV_SEL_O,
  output logic STOP_HOLD_O,
  output logic KEY_IRQ_EN_O,
  output logic TIMER8_EXT_ONLY_O,
  output logic WAKE_ACK_O,
  output logic WAKE_BRANCH_O,
  output logic WAKE_DONE_O
);

  // Pin synchronisers
  logic nmi_s1_reg;
  logic nmi_s2_reg;
  logic [`EXT_IRQ_N-1:0] ext_s1_reg;
  logic [`EXT_IRQ_N-1:0] ext_s2_reg;

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
    end else begin
      nmi_s1_reg <= NMI_PIN_I;
      nmi_s2_reg <= nmi_s1_reg;
      ext_s1_reg <= EXT_IRQ_PIN_I;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  function automatic logic [`CNT_W-1:0] settle_len(input logic [`SETTLE_SEL_W-1:0] sel);
    settle_len = `CNT_W'(1) << (SETTLE_BASE + int'(sel));
  endfunction

  // State and registers
  pwr_state_t state_reg, state_next;
  logic [`CNT_W-1:0] cnt_reg, cnt_next;
  wake_plan_t plan_reg, plan_next;
  logic deep_mode_select;
  logic wdt_nmi_wake_mask;
  logic pin_nmi_wake_mask;
  logic maskable_wake_mask;
  logic [`SETTLE_SEL_W-1:0] osc_settle_select_reg;
  logic subclock_select;
  logic main_osc_stop;
  logic [`DIV_MSB:0] clock_divider_select;
  logic rdy_reg;
  logic err_reg;
  logic [31:0] rdata_reg;

  // Bus decode
  wire setup_hit = PSEL_I & PENABLE_I & ~rdy_reg;
  wire acc_done = PSEL_I & PENABLE_I & rdy_reg;
  wire wr_en = acc_done & PWRITE_I & ~err_reg;
  wire sel_mode = PADDR_I == `OFS_PSMODE;
  wire sel_ctrl = PADDR_I == `OFS_PSCTRL;
  wire sel_osc = PADDR_I == `OFS_OSCSET;
  wire sel_pcc = PADDR_I == `OFS_PCLOCK;
  wire sel_stat = PADDR_I == `OFS_STATUS;
  wire addr_ok = sel_mode | sel_ctrl | sel_osc | sel_pcc | sel_stat;
  wire status_ro = sel_stat & PWRITE_I;

  wire [31:0] mode_rd = 32'(deep_mode_select) << `BIT_DEEP;
  wire [31:0] ctrl_rd = (32'(maskable_wake_mask) << `BIT_MASKABLE_M) |
                        (32'(pin_nmi_wake_mask) << `BIT_PIN_NMI_M) |
                        (32'(wdt_nmi_wake_mask) << `BIT_WDT_NMI_M);
  wire [31:0] pcc_rd = 32'(clock_divider_select) |
                       (32'(subclock_select) << `BIT_SUBSEL) |
                       (32'(main_osc_stop) << `BIT_MAINSTOP);
  wire [31:0] stat_rd = {28'h0000000, SYS_CLK_SUB_O, MAIN_OSC_EN_O, 2'(state_reg)};
  wire [31:0] rd_mux = sel_mode ? mode_rd :
                       sel_ctrl ? ctrl_rd :
                       sel_osc ? 32'(osc_settle_select_reg) :
                       sel_pcc ? pcc_rd :
                       sel_stat ? stat_rd : 32'h00000000;

  // Wake sources
  // Watchdog and peripheral requests share this clock, so they skip the synchroniser
  wire on_sub = subclock_select;
  wire soft_reset = WATCHDOG2_RESET_I & on_sub;
  wire [`EXT_IRQ_N-1:0] ext_live = ext_s2_reg & EXT_IRQ_EN_I;
  wake_req_t wake;
  assign wake.nmi = (nmi_s2_reg & ~pin_nmi_wake_mask) |
                    (WATCHDOG2_IRQ_I & on_sub & ~wdt_nmi_wake_mask);
  assign wake.maskable = ((|ext_live) | PERIPH_IRQ_I) & ~maskable_wake_mask;
  wire wake_any = wake.nmi | wake.maskable;
  wire req_higher = REQ_PRIO_I < SERVICE_PRIO_I;
  wire mask_ack = ~IN_SERVICE_I | req_higher;
  wire stop_req = wr_en & sel_ctrl & PWDATA_I[`BIT_STANDBY];
  wire enter_stop = (state_reg == ST_RUN) & stop_req & deep_mode_select;

  // Sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    plan_next = plan_reg;
    case (state_reg)
      ST_RUN: begin
        plan_next = '0;
        if (enter_stop) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wake_any) begin
          state_next = ST_SETTLE;
          cnt_next = settle_len(osc_settle_select_reg) - `CNT_W'(1);
          plan_next.from_irq = 1'b1;
          if (wake.nmi) begin
            plan_next.ack = 1'b1;
            plan_next.branch = 1'b1;
          end else begin
            plan_next.ack = mask_ack & INT_ENABLE_I;
            plan_next.branch = mask_ack & INT_ENABLE_I;
          end
        end
      end
      ST_SETTLE: begin
        if (cnt_reg == '0) begin
          state_next = ST_RUN;
        end else begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
    if (soft_reset) begin
      state_next = ST_SETTLE;
      cnt_next = `CNT_W'(RESET_SETTLE_CYC - 1);
      plan_next = '0;
    end
  end

  wire resume = (state_reg == ST_SETTLE) & (state_next == ST_RUN);
  wire stopped_next = state_next != ST_RUN;
  wire main_off_next = (state_next == ST_STOP) | (subclock_select & main_osc_stop);

  // Reset enters settling with the default wait, as after power-up
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg <= ST_SETTLE;
      cnt_reg <= `CNT_W'(RESET_SETTLE_CYC - 1);
      plan_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      plan_reg <= plan_next;
    end
  end

  // Software registers; the standby request bit is a strobe and is not stored
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      deep_mode_select <= 1'b0;
      wdt_nmi_wake_mask <= 1'b0;
      pin_nmi_wake_mask <= 1'b0;
      maskable_wake_mask <= 1'b0;
      osc_settle_select_reg <= `SETTLE_SEL_RST;
      subclock_select <= 1'b0;
      main_osc_stop <= 1'b0;
      clock_divider_select <= `DIV_RST;
    end else if (soft_reset) begin
      deep_mode_select <= 1'b0;
      wdt_nmi_wake_mask <= 1'b0;
      pin_nmi_wake_mask <= 1'b0;
      maskable_wake_mask <= 1'b0;
      osc_settle_select_reg <= `SETTLE_SEL_RST;
      subclock_select <= 1'b0;
      main_osc_stop <= 1'b0;
      clock_divider_select <= `DIV_RST;
    end else if (WATCHDOG1_RESET_I) begin
      // Main oscillator never stops here, so no settling wait
      subclock_select <= 1'b0;
      main_osc_stop <= 1'b0;
      clock_divider_select <= `DIV_RST;
    end else if (wr_en) begin
      if (sel_mode) begin
        deep_mode_select <= PWDATA_I[`BIT_DEEP];
      end
      if (sel_ctrl) begin
        maskable_wake_mask <= PWDATA_I[`BIT_MASKABLE_M];
        pin_nmi_wake_mask <= PWDATA_I[`BIT_PIN_NMI_M];
        wdt_nmi_wake_mask <= PWDATA_I[`BIT_WDT_NMI_M];
      end
      if (sel_osc) begin
        osc_settle_select_reg <= PWDATA_I[`SETTLE_SEL_W-1:0];
      end
      if (sel_pcc) begin
        clock_divider_select <= PWDATA_I[`DIV_MSB:0];
        subclock_select <= PWDATA_I[`BIT_SUBSEL];
        main_osc_stop <= PWDATA_I[`BIT_MAINSTOP];
      end
    end
  end

  // Bus answer: one wait state so every bus output comes from a flop
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      rdy_reg <= setup_hit;
      err_reg <= setup_hit & (~addr_ok | status_ro);
      rdata_reg <= (setup_hit & ~PWRITE_I) ? rd_mux : 32'h00000000;
    end
  end

  // Clock and peripheral controls; RAM and CPU state simply stay frozen
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      MAIN_OSC_EN_O <= 1'b0;
      // Subclock and key interrupt never stop, not even in reset
      SUB_OSC_EN_O <= 1'b1;
      KEY_IRQ_EN_O <= 1'b1;
      CPU_CLK_EN_O <= 1'b0;
      PERIPH_CLK_EN_O <= 1'b0;
      SYS_CLK_SUB_O <= 1'b0;
      CLK_DIV_SEL_O <= `DIV_RST;
      STOP_HOLD_O <= 1'b0;
      TIMER8_EXT_ONLY_O <= 1'b0;
      WAKE_ACK_O <= 1'b0;
      WAKE_BRANCH_O <= 1'b0;
      WAKE_DONE_O <= 1'b0;
    end else begin
      MAIN_OSC_EN_O <= ~main_off_next;
      SUB_OSC_EN_O <= 1'b1;
      KEY_IRQ_EN_O <= 1'b1;
      CPU_CLK_EN_O <= ~stopped_next;
      PERIPH_CLK_EN_O <= ~stopped_next;
      SYS_CLK_SUB_O <= subclock_select;
      CLK_DIV_SEL_O <= clock_divider_select;
      STOP_HOLD_O <= state_next == ST_STOP;
      TIMER8_EXT_ONLY_O <= (state_next == ST_STOP) & ~TIMER16_WT_EN_I;
      WAKE_ACK_O <= resume & plan_reg.from_irq & plan_reg.ack;
      WAKE_BRANCH_O <= resume & plan_reg.from_irq & plan_reg.branch;
      WAKE_DONE_O <= resume;
    end
  end

  assign PREADY_O = rdy_reg;
  assign PSLVERR_O = err_reg;
  assign PRDATA_O = rdata_reg;

  // Checks
  sequence stop_entry_s;
    (state_reg == ST_RUN) && enter_stop;
  endsequence

  sequence irq_wake_s;
    (state_reg == ST_STOP) && wake_any && !soft_reset;
  endsequence

  stop_entry_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (stop_entry_s and !soft_reset) |=> state_reg == ST_STOP ##0 !CPU_CLK_EN_O && !MAIN_OSC_EN_O)
    else $error("stop not entered");

  osc_halt_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    state_reg == ST_STOP |-> !MAIN_OSC_EN_O && !PERIPH_CLK_EN_O && SUB_OSC_EN_O)
    else $error("clocks running in stop");

  port_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    STOP_HOLD_O == (state_reg == ST_STOP))
    else $error("port hold mismatch");

  masked_stay_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (state_reg == ST_STOP) && !wake_any && !soft_reset |=> state_reg == ST_STOP)
    else $error("stop left without wake source");

  irq_settle_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    irq_wake_s |=> state_reg == ST_SETTLE && cnt_reg == settle_len(osc_settle_select_reg) - `CNT_W'(1))
    else $error("wrong settling count");

  settle_wait_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (state_reg == ST_SETTLE) && (cnt_reg != '0) && !soft_reset |=> state_reg == ST_SETTLE)
    else $error("resumed before settling");

  nmi_branch_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (irq_wake_s and (wake.nmi && osc_settle_select_reg == '0 && SETTLE_BASE == 0))
    |=> ##1 WAKE_ACK_O && WAKE_BRANCH_O)
    else $error("nmi wake not acknowledged");

  low_prio_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (irq_wake_s and (!wake.nmi && IN_SERVICE_I && !req_higher)) |=> !plan_reg.ack && !plan_reg.branch)
    else $error("lower priority request acknowledged");

  sub_select_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    $rose(subclock_select) |=> SYS_CLK_SUB_O)
    else $error("subclock not selected");

  main_stop_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    subclock_select && main_osc_stop |=> !MAIN_OSC_EN_O)
    else $error("main oscillator still running");

  wdt1_clear_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    WATCHDOG1_RESET_I && !soft_reset |=> !subclock_select ##1 !SYS_CLK_SUB_O)
    else $error("subclock kept after reset");

  reset_wait_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    soft_reset |=> state_reg == ST_SETTLE && cnt_reg == `CNT_W'(RESET_SETTLE_CYC - 1) && !subclock_select)
    else $error("watchdog reset wait not loaded");

  wdt2_wake_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (state_reg == ST_STOP) && WATCHDOG2_IRQ_I && on_sub && !wdt_nmi_wake_mask && !soft_reset
    |=> state_reg == ST_SETTLE && plan_reg.ack)
    else $error("watchdog2 wake missed");

endmodule
`default_nettype wire

//--- irq_source_model.sv
// Interrupt-side model raising wake requests and holding them until served
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] fire_i,
  input wire logic [2:0] pin_i,
  input wire logic done_i,
  output logic nmi_o,
  output logic [6:0] ext_o,
  output logic periph_o
);
  // Levels stay up until the wake completes, as a real controller keeps them pending
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nmi_o <= 1'b0;
      ext_o <= 7'h00;
      periph_o <= 1'b0;
    end else if (done_i) begin
      nmi_o <= 1'b0;
      ext_o <= 7'h00;
      periph_o <= 1'b0;
    end else begin
      if (fire_i == 2'h1) nmi_o <= 1'b1;
      if (fire_i == 2'h2) ext_o[pin_i] <= 1'b1;
      if (fire_i == 2'h3) periph_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- standby_stop_subclock_control_tb.sv
// Self-checking bench for the standby controller
`timescale 1ns/1ps
`default_nettype none
module standby_stop_subclock_control_tb;
  import standby_pkg::*;
  localparam int RST_CYC = 8;
  logic clk, rst_n, psel, penable, pwrite, in_svc, int_en, t16, wd1, wd2i, wd2r, nmi, periph;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] ext, en;
  logic [2:0] svc_p, req_p, pin, div;
  logic [1:0] fire;
  logic pready, pslverr, mosc, sosc, cpuc, perc, ssub, hold, key, t8, ack, br, done;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  standby_stop_subclock_control #(.RESET_SETTLE_CYC(RST_CYC), .SETTLE_BASE(0)) i_dut (
    .MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .NMI_PIN_I(nmi), .EXT_IRQ_PIN_I(ext), .EXT_IRQ_EN_I(en), .PERIPH_IRQ_I(periph),
    .WATCHDOG2_IRQ_I(wd2i), .WATCHDOG2_RESET_I(wd2r), .WATCHDOG1_RESET_I(wd1),
    .IN_SERVICE_I(in_svc), .SERVICE_PRIO_I(svc_p), .REQ_PRIO_I(req_p), .INT_ENABLE_I(int_en),
    .TIMER16_WT_EN_I(t16), .MAIN_OSC_EN_O(mosc), .SUB_OSC_EN_O(sosc), .CPU_CLK_EN_O(cpuc),
    .PERIPH_CLK_EN_O(perc), .SYS_CLK_SUB_O(ssub), .CLK_DIV_SEL_O(div), .STOP_HOLD_O(hold),
    .KEY_IRQ_EN_O(key), .TIMER8_EXT_ONLY_O(t8), .WAKE_ACK_O(ack), .WAKE_BRANCH_O(br),
    .WAKE_DONE_O(done));
  irq_source_model i_irq (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .pin_i(pin),
    .done_i(done), .nmi_o(nmi), .ext_o(ext), .periph_o(periph));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 3000);
  endtask
  task automatic do_reset();
    int n;
    logic [31:0] r;
    logic e;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_done(n);
    check(n >= RST_CYC - 1 && n <= RST_CYC + 3, 1, "reset settle length");
    @(negedge clk);
    check({cpuc, perc, mosc, sosc, key, hold, ssub, div}, 10'h3e3, "outputs after reset");
    apb(0, 8'h08, 0, r, e);
    check(r, 32'h2, "settle select reset");
    apb(0, 8'h0c, 0, r, e);
    check(r, 32'h3, "clock reg reset");
    apb(0, 8'h10, 0, r, e);
    check(r, 32'h4, "status after reset");
    apb(0, 8'h14, 0, r, e);
    check(e, 1, "unmapped address error");
    apb(1, 8'h10, 32'h0, r, e);
    check(e, 1, "status write error");
    $display("test reset done");
  endtask
  initial begin
    int n, sel, src, p, sp;
    logic [31:0] r;
    logic e, xa;
    {psel, penable, pwrite, paddr, pwdata, in_svc, int_en, t16, wd1, wd2i, wd2r} = '0;
    {svc_p, req_p, pin, fire} = '0;
    en = 7'h7f;
    rst_n = 1'b0;
    r = $urandom(41028);
    do_reset();
    apb(1, 8'h00, 32'h0, r, e);
    apb(1, 8'h04, 32'h2, r, e);
    repeat (5) @(posedge clk);
    check({hold, cpuc}, 2'b01, "request ignored without deep mode");
    for (int i = 0; i < 12; i++) begin
      src = 1 + i % 3;
      sel = (i == 0) ? 0 : $urandom_range(0, 3);
      p = $urandom_range(0, 6);
      sp = $urandom_range(0, 7);
      {in_svc, int_en, t16} <= (i == 4) ? 3'b110 : 3'($urandom_range(0, 7));
      svc_p <= 3'(sp);
      req_p <= (i == 4) ? 3'(sp) : 3'($urandom_range(0, 7));
      pin <= 3'(p);
      en <= 7'($urandom) | (7'h01 << p);
      apb(1, 8'h08, 32'(sel), r, e);
      apb(1, 8'h00, 32'h1, r, e);
      apb(1, 8'h04, (i % 4 == 3) ? 32'h12 : 32'h02, r, e);
      repeat (5) @(posedge clk);
      check({hold, cpuc, perc, mosc, sosc, key}, 6'h23, "stop entered");
      check(t8, !t16, "timer8 source in stop");
      if (i % 4 == 3) begin
        fire <= 2'h3;
        repeat (20) @(posedge clk);
        check(hold, 1, "masked request keeps stop");
        src = 1;
      end
      fire <= 2'(src);
      @(posedge clk);
      fire <= 2'h0;
      wait_done(n);
      xa = (src == 1) || ((!in_svc || req_p < svc_p) && int_en);
      check(n >= (1 << sel) && n <= (1 << sel) + 6, 1, "wake settle length");
      check({ack, br}, {xa, xa}, "ack and branch");
      @(negedge clk);
      check({hold, cpuc, mosc}, 3'b011, "back in run");
      apb(1, 8'h04, 32'h0, r, e);
    end
    $display("test stop wake done");
    apb(1, 8'h0c, 32'h0b, r, e);
    repeat (2) @(negedge clk);
    check({ssub, div}, 4'hb, "subclock selected");
    apb(1, 8'h0c, 32'h4b, r, e);
    repeat (2) @(negedge clk);
    check({mosc, ssub}, 2'b01, "main osc stopped");
    apb(1, 8'h0c, 32'h0b, r, e);
    repeat (2) @(negedge clk);
    check(mosc, 1, "main osc restarted");
    repeat (8) @(posedge clk);
    apb(1, 8'h0c, 32'h03, r, e);
    repeat (2) @(negedge clk);
    check(ssub, 0, "normal clocking restored");
    apb(1, 8'h0c, 32'h0b, r, e);
    wd1 <= 1'b1;
    @(posedge clk);
    wd1 <= 1'b0;
    repeat (3) @(negedge clk);
    check({ssub, mosc}, 2'b01, "watchdog1 reset leaves subclock");
    apb(1, 8'h0c, 32'h0b, r, e);
    apb(1, 8'h00, 32'h1, r, e);
    apb(1, 8'h04, 32'h2, r, e);
    repeat (5) @(posedge clk);
    check(hold, 1, "stop on subclock");
    wd2i <= 1'b1;
    wait_done(n);
    check({ack, br}, 2'b11, "watchdog2 irq wake");
    @(posedge clk);
    wd2i <= 1'b0;
    wd2r <= 1'b1;
    @(posedge clk);
    wd2r <= 1'b0;
    wait_done(n);
    check(n >= RST_CYC && n <= RST_CYC + 3, 1, "watchdog2 reset wait");
    check({ack, br, ssub}, 3'b000, "watchdog2 reset state");
    $display("test subclock done");
    apb(1, 8'h00, 32'h1, r, e);
    apb(1, 8'h04, 32'h2, r, e);
    repeat (5) @(posedge clk);
    check(hold, 1, "stop before reset wake");
    wd2i <= 1'b1;
    repeat (6) @(posedge clk);
    check(hold, 1, "watchdog2 irq ignored on main clock");
    wd2i <= 1'b0;
    do_reset();
    test_done();
  end
endmodule
`default_nettype wire
